// ### logic/sdbca_core.sv
/*
 * sdbca_core: command decode, bank/row tracking, burst column engine and
 * read latency pipe of a quad-bank SDRAM, 16-bit organisation.
 * Assumes a cell array on clk_sys with one cycle read latency.
 */
// Overview of operation
// - all pins sampled on clk_sys rising edge only, through two flip-flops
// - activate: two bank selects choose bank, twelve address lines choose row
// - address with read or write gives burst start column in open row
// - column width follows data width; this part uses 512 columns on bits 0-8
// - burst length 1, 2, 4, 8 or full page; burst terminate cuts burst
// - following columns generated internally in programmed count and order
// - auto precharge closes row by itself when burst finishes
// - new column command accepted every cycle without gaps
// - one bank may be precharged while another is accessed
`timescale 1ns/10ps
module sdbca_core (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // command pins
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic bank_select_0,
    input wire logic bank_select_1,
    input wire logic [sdbca_pkg::ROW_W-1:0] row_column_address,
    input wire logic low_byte_mask,
    input wire logic high_byte_mask,
    // data pins
    input wire logic [sdbca_pkg::DATA_W-1:0] data_line_in,
    output logic [sdbca_pkg::DATA_W-1:0] data_line_out,
    output logic [1:0] data_line_oe,
    // mode
    input wire logic [2:0] burst_length_setting,
    input wire logic burst_interleave,
    input wire logic [1:0] read_latency_setting,
    // cell array
    output logic [1:0] array_bank,
    output logic [sdbca_pkg::ROW_W-1:0] array_row,
    output logic [sdbca_pkg::COL_W-1:0] array_col,
    output logic array_rd_en,
    output logic array_wr_en,
    output logic [sdbca_pkg::DATA_W-1:0] array_wr_data,
    output logic [1:0] array_wr_byte_en,
    input wire logic [sdbca_pkg::DATA_W-1:0] array_rd_data,
    // status
    output logic [sdbca_pkg::BANKS-1:0] bank_open,
    output logic [sdbca_pkg::ROW_W-1:0] refresh_row,
    output logic access_closed_err
);
    import sdbca_pkg::*;

    localparam int PIN_W = 4 + 2 + ROW_W + 2 + DATA_W;

    logic [PIN_W-1:0] pin_s1_q;
    logic [PIN_W-1:0] pin_s2_q;
    logic [2:0] cmd;
    logic sel;
    logic [1:0] bank;
    logic [ROW_W-1:0] addr;
    logic [1:0] mask;
    logic [DATA_W-1:0] din;
    logic is_act, is_rd, is_wr, is_pre, is_ref, is_bst, is_rw, hit;

    // two flops on every pin before decode
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q <= '1;
            pin_s2_q <= '1;
        end else begin
            pin_s1_q <= {cs_n, ras_n, cas_n, we_n, bank_select_1, bank_select_0,
                         row_column_address, high_byte_mask, low_byte_mask, data_line_in};
            pin_s2_q <= pin_s1_q;
        end
    end

    always_comb begin
        sel = ~pin_s2_q[PIN_W-1];
        cmd = pin_s2_q[PIN_W-2 -: 3];
        bank = pin_s2_q[PIN_W-5 -: 2];
        addr = pin_s2_q[PIN_W-7 -: ROW_W];
        mask = pin_s2_q[DATA_W +: 2];
        din = pin_s2_q[DATA_W-1:0];
        is_act = sel && cmd == CMD_ACT;
        is_rd = sel && cmd == CMD_RD;
        is_wr = sel && cmd == CMD_WR;
        is_pre = sel && cmd == CMD_PRE;
        is_ref = sel && cmd == CMD_REF;
        is_bst = sel && cmd == CMD_BST;
        is_rw = is_rd || is_wr;
    end

    // bank and row tracking
    logic [ROW_W-1:0] bank_row_q [BANKS];
    logic [BANKS-1:0] bank_open_q;
    logic [BANKS-1:0] ap_close;

    always_comb begin
        hit = bank_open_q[bank];
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bank_open_q <= '0;
            for (int i = 0; i < BANKS; i++) begin
                bank_row_q[i] <= ROW_RST;
            end
        end else begin
            for (int i = 0; i < BANKS; i++) begin
                if (is_act && bank == 2'(i)) begin
                    bank_open_q[i] <= 1'b1;
                    bank_row_q[i] <= addr;
                end else if (is_pre && (addr[AP_BIT] || bank == 2'(i))) begin
                    bank_open_q[i] <= 1'b0;
                end else if (ap_close[i]) begin
                    bank_open_q[i] <= 1'b0;
                end
            end
        end
    end

    // burst engine
    sdbca_burst_e state_q;
    logic [1:0] bbank_q;
    logic [COL_W-1:0] start_q;
    logic [CNT_W-1:0] beat_q;
    logic ap_q;
    logic [CNT_W-1:0] blen;
    logic [COL_W-1:0] next_col;
    logic cont;
    logic done;

    always_comb begin
        case (burst_length_setting)
            BL_2: blen = 10'h002;
            BL_4: blen = 10'h004;
            BL_8: blen = 10'h008;
            BL_PAGE: blen = 10'h3FF;
            default: blen = 10'h001;
        endcase
        cont = state_q != SDBCA_IDLE && !is_bst && !is_rw;
        // full page never ends by itself
        done = burst_length_setting != BL_PAGE && beat_q >= blen;
        ap_close = '0;
        if (state_q != SDBCA_IDLE && ap_q && (done || is_rw || is_bst)) begin
            ap_close[bbank_q] = 1'b1;
        end
    end

    sdbca_col_gen u_col_gen (
        .start_col(start_q),
        .beat(beat_q),
        .burst_length_setting(burst_length_setting),
        .burst_interleave(burst_interleave),
        .col(next_col)
    );

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= SDBCA_IDLE;
            bbank_q <= 2'h0;
            start_q <= '0;
            beat_q <= '0;
            ap_q <= 1'b0;
        end else begin
            if (is_rw && hit) begin
                state_q <= is_rd ? SDBCA_READ : SDBCA_WRITE;
                bbank_q <= bank;
                start_q <= addr[COL_W-1:0];
                beat_q <= 10'h001;
                ap_q <= addr[AP_BIT];
            end else if (is_bst || (is_rw && !hit)) begin
                state_q <= SDBCA_IDLE;
            end else if (state_q != SDBCA_IDLE) begin
                if (done) begin
                    state_q <= SDBCA_IDLE;
                end else begin
                    beat_q <= CNT_W'(beat_q + 10'h001);
                end
            end
        end
    end

    // array access, one beat per cycle
    logic [1:0] arr_bank_q;
    logic [COL_W-1:0] arr_col_q;
    logic [ROW_W-1:0] arr_row_q;
    logic arr_rd_q, arr_wr_q;
    logic [DATA_W-1:0] arr_wd_q;
    logic [1:0] arr_be_q;
    logic err_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            arr_bank_q <= 2'h0;
            arr_col_q <= '0;
            arr_row_q <= ROW_RST;
            arr_rd_q <= 1'b0;
            arr_wr_q <= 1'b0;
            arr_wd_q <= '0;
            arr_be_q <= 2'h0;
            err_q <= 1'b0;
        end else begin
            arr_wd_q <= din;
            arr_be_q <= ~mask;
            err_q <= is_rw && !hit;
            if (is_rw && hit) begin
                arr_bank_q <= bank;
                arr_col_q <= addr[COL_W-1:0];
                arr_row_q <= bank_row_q[bank];
                arr_rd_q <= is_rd;
                arr_wr_q <= is_wr;
            end else if (cont && !done) begin
                arr_bank_q <= bbank_q;
                arr_col_q <= next_col;
                arr_row_q <= bank_row_q[bbank_q];
                arr_rd_q <= state_q == SDBCA_READ;
                arr_wr_q <= state_q == SDBCA_WRITE;
            end else begin
                arr_rd_q <= 1'b0;
                arr_wr_q <= 1'b0;
            end
        end
    end

    // read latency pipe; array data arrives one cycle after the read enable
    logic rd_d1_q;
    logic [1:0] rmask_q;
    logic [RD_PIPE-1:0] pv_q;
    logic [1:0] pm_q [RD_PIPE];
    logic [DATA_W-1:0] pd_q [RD_PIPE];
    logic [1:0] lat;
    logic [DATA_W-1:0] dout_q;
    logic [1:0] oe_q;

    always_comb begin
        lat = read_latency_setting == 2'h0 ? 2'h0 : 2'(read_latency_setting - 2'h1);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_d1_q <= 1'b0;
            rmask_q <= 2'h0;
            pv_q[0] <= 1'b0;
            pm_q[0] <= 2'h0;
            pd_q[0] <= '0;
        end else begin
            rd_d1_q <= arr_rd_q;
            rmask_q <= mask;
            pv_q[0] <= rd_d1_q;
            pm_q[0] <= rmask_q;
            pd_q[0] <= array_rd_data;
        end
    end

    genvar g;
    generate
        for (g = 1; g < RD_PIPE; g++) begin : g_rd_pipe
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    pv_q[g] <= 1'b0;
                    pm_q[g] <= 2'h0;
                    pd_q[g] <= '0;
                end else begin
                    pv_q[g] <= pv_q[g-1];
                    pm_q[g] <= pm_q[g-1];
                    pd_q[g] <= pd_q[g-1];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dout_q <= '0;
            oe_q <= 2'h0;
        end else begin
            dout_q <= pd_q[lat];
            oe_q <= {2{pv_q[lat]}} & ~pm_q[lat];
        end
    end

    // refresh walks rows; interval kept by the controller
    logic [ROW_W-1:0] ref_row_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ref_row_q <= ROW_RST;
        end else if (is_ref) begin
            ref_row_q <= ROW_W'(ref_row_q + 12'h001);
        end
    end

    assign data_line_out = dout_q;
    assign data_line_oe = oe_q;
    assign array_bank = arr_bank_q;
    assign array_row = arr_row_q;
    assign array_col = arr_col_q;
    assign array_rd_en = arr_rd_q;
    assign array_wr_en = arr_wr_q;
    assign array_wr_data = arr_wd_q;
    assign array_wr_byte_en = arr_be_q;
    assign bank_open = bank_open_q;
    assign refresh_row = ref_row_q;
    assign access_closed_err = err_q;

    a_pin_two_flops: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_act |-> $past(cs_n, 2) == 1'b0 && $past(ras_n, 2) == 1'b0)
        else $error("activate decoded without pins two cycles earlier");
    a_closed_no_access: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_rw && !hit |=> !arr_rd_q && !arr_wr_q && err_q)
        else $error("access to closed bank reached array");
    a_act_opens_row: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_act |=> bank_open_q[$past(bank)] && bank_row_q[$past(bank)] == $past(addr))
        else $error("activate did not open the addressed row");
    a_start_column: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_rw && hit |=> arr_col_q == $past(addr[COL_W-1:0]) && arr_bank_q == $past(bank))
        else $error("burst did not start at given column");
    a_term_stops: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_bst |=> state_q == SDBCA_IDLE && !arr_rd_q && !arr_wr_q)
        else $error("burst terminate did not stop burst");
    a_bl4_beats: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_rd && hit && burst_length_setting == BL_4 ##1 (!is_rw && !is_bst)[*4]
        |-> arr_rd_q ##1 !arr_rd_q)
        else $error("burst of four did not give four beats");
    a_autopre_close: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q != SDBCA_IDLE && ap_q && done && !is_act |=> !bank_open_q[$past(bbank_q)])
        else $error("auto precharge did not close the bank");
    a_back_to_back: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (is_rd && hit) [*2] |=> arr_rd_q && arr_col_q == $past(addr[COL_W-1:0]))
        else $error("back to back column command lost");
    a_pre_other_bank: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_pre && !addr[AP_BIT] && bank != bbank_q && state_q == SDBCA_READ && !done
        |=> arr_rd_q)
        else $error("precharge of another bank stalled the burst");
endmodule : sdbca_core

// ### logic/sdbca_pkg.sv
/*
 * sdbca_pkg: constants for the bank command and access core of a quad-bank SDRAM.
 * Assumes one system clock; the device is fixed to the 16-bit data organisation.
 */
package sdbca_pkg;
    // geometry
    localparam int BANKS = 4;
    localparam int ROW_W = 12;
    localparam int ROWS = 4096;
    localparam int COLS_X4 = 2048;
    localparam int COLS_X8 = 1024;
    localparam int COLS_X16 = 512;
    localparam int COL_W = 9;
    localparam int CNT_W = 10;
    localparam int DATA_W = 16;
    localparam int AP_BIT = 10;
    localparam int RD_PIPE = 3;
    // command codes on {row strobe, column strobe, write strobe}, chip select low
    localparam logic [2:0] CMD_LMR = 3'h0;
    localparam logic [2:0] CMD_REF = 3'h1;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_WR = 3'h4;
    localparam logic [2:0] CMD_RD = 3'h5;
    localparam logic [2:0] CMD_BST = 3'h6;
    localparam logic [2:0] CMD_NOP = 3'h7;
    // burst length codes
    localparam logic [2:0] BL_1 = 3'h0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;
    // refresh
    localparam int REF_CYCLES = 4096;
    localparam int REF_MS_STD = 64;
    localparam int REF_MS_AUTO = 16;
    localparam logic [ROW_W-1:0] ROW_RST = 12'h000;
    typedef enum logic [1:0] {SDBCA_IDLE, SDBCA_READ, SDBCA_WRITE} sdbca_burst_e;
endpackage : sdbca_pkg

// ### logic/sdbca_col_gen.sv
/*
 * sdbca_col_gen: column of beat n of a burst from its start column.
 * Assumes the count never reaches the burst length for fixed bursts.
 */
`timescale 1ns/10ps
module sdbca_col_gen (
    // burst description
    input wire logic [sdbca_pkg::COL_W-1:0] start_col,
    input wire logic [sdbca_pkg::CNT_W-1:0] beat,
    input wire logic [2:0] burst_length_setting,
    input wire logic burst_interleave,
    // result
    output logic [sdbca_pkg::COL_W-1:0] col
);
    import sdbca_pkg::*;

    function automatic logic [COL_W-1:0] low_mask(input logic [2:0] bl);
        if (bl == BL_2) begin
            low_mask = 9'h001;
        end else if (bl == BL_4) begin
            low_mask = 9'h003;
        end else if (bl == BL_8) begin
            low_mask = 9'h007;
        end else if (bl == BL_PAGE) begin
            low_mask = 9'h1FF;
        end else begin
            low_mask = 9'h000;
        end
    endfunction : low_mask

    logic [COL_W-1:0] m;
    logic [COL_W-1:0] b;
    logic [COL_W-1:0] seq;

    always_comb begin
        m = low_mask(burst_length_setting);
        b = beat[COL_W-1:0];
        seq = COL_W'(start_col + b);
        // wrap inside the aligned block; full page only runs sequentially
        if (burst_interleave && burst_length_setting != BL_PAGE) begin
            col = (start_col & ~m) | ((start_col ^ b) & m);
        end else begin
            col = (start_col & ~m) | (seq & m);
        end
    end
endmodule : sdbca_col_gen

// ### tb/sdbca_ctl_model.sv
/* sdbca_ctl_model: memory controller model on the command and data pins.
   Assumes the bench calls its tasks in clk_sys time, one command per edge. */
`timescale 1ns/10ps
module sdbca_ctl_model (
    // clock
    input wire logic clk_sys,
    // command pins
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic bank_select_0,
    output logic bank_select_1,
    output logic [sdbca_pkg::ROW_W-1:0] row_column_address,
    output logic low_byte_mask,
    output logic high_byte_mask,
    // data pins
    output logic [sdbca_pkg::DATA_W-1:0] data_line_in
);
    import sdbca_pkg::*;
    initial begin
        {cs_n, ras_n, cas_n, we_n} = 4'hF;
        {bank_select_1, bank_select_0} = 2'h0;
        row_column_address = 12'h000;
        {high_byte_mask, low_byte_mask} = 2'h0;
        data_line_in = 16'h0000;
    end
    task automatic cmd(input logic [2:0] code, input logic [1:0] bank,
            input logic [11:0] addr, input logic [15:0] data, input logic [1:0] mask);
        @(posedge clk_sys);
        cs_n <= 1'b0;
        {ras_n, cas_n, we_n} <= code;
        {bank_select_1, bank_select_0} <= bank;
        row_column_address <= addr;
        {high_byte_mask, low_byte_mask} <= mask;
        data_line_in <= data;
    endtask : cmd
    // released bus toggles so a stale word cannot pass for data
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            {cs_n, ras_n, cas_n, we_n} <= 4'hF;
            data_line_in <= ~data_line_in;
        end
    endtask : idle
endmodule : sdbca_ctl_model

// ### tb/tb_top.sv
/* tb_top: self-checking bench for sdbca_core with a controller model and
   a one-cycle cell array model. Assumes clk_sys at 125 MHz. */
`timescale 1ns/10ps
module tb_top;
    import sdbca_pkg::*;
    logic clk_sys, rst_n, cs_n, ras_n, cas_n, we_n, bank_select_0, bank_select_1;
    logic low_byte_mask, high_byte_mask, burst_interleave;
    logic array_rd_en, array_wr_en, access_closed_err;
    logic [ROW_W-1:0] row_column_address, array_row, refresh_row;
    logic [DATA_W-1:0] data_line_in, data_line_out, array_wr_data, array_rd_data;
    logic [1:0] data_line_oe, array_bank, array_wr_byte_en, read_latency_setting;
    logic [2:0] burst_length_setting;
    logic [COL_W-1:0] array_col;
    logic [BANKS-1:0] bank_open;
    int fail_count = 0;
    int n_compared = 0;
    int err_seen = 0;
    logic [31:0] rng = 32'h00000020;
    logic [22:0] ga_q[$], ea_q[$];
    logic [17:0] gw_q[$], ew_q[$];

    sdbca_ctl_model ctl (.clk_sys, .cs_n, .ras_n, .cas_n, .we_n, .bank_select_0,
        .bank_select_1, .row_column_address, .low_byte_mask, .high_byte_mask, .data_line_in);
    sdbca_core dut (.clk_sys, .rst_n, .cs_n, .ras_n, .cas_n, .we_n, .bank_select_0,
        .bank_select_1, .row_column_address, .low_byte_mask, .high_byte_mask,
        .data_line_in, .data_line_out, .data_line_oe, .burst_length_setting,
        .burst_interleave, .read_latency_setting, .array_bank, .array_row, .array_col,
        .array_rd_en, .array_wr_en, .array_wr_data, .array_wr_byte_en, .array_rd_data,
        .bank_open, .refresh_row, .access_closed_err);

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // cell array answers with its own address; monitor of beats and pins
    always @(posedge clk_sys) begin
        array_rd_data <= {array_bank, array_row[4:0], array_col};
        if (array_rd_en === 1'b1 || array_wr_en === 1'b1) begin
            ga_q.push_back({array_bank, array_row, array_col});
        end
        if (array_wr_en === 1'b1) begin
            gw_q.push_back({array_wr_byte_en, array_wr_data});
        end
        if (data_line_oe !== 2'h0) begin
            gw_q.push_back({data_line_oe, data_line_out});
        end
        if (access_closed_err === 1'b1) begin
            err_seen++;
        end
    end

    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : rnd

    function automatic int blen();
        case (burst_length_setting)
            BL_2: return 2;
            BL_4: return 4;
            BL_8: return 8;
            BL_PAGE: return 512;
            default: return 1;
        endcase
    endfunction : blen

    function automatic logic [8:0] colx(input logic [8:0] s, input int n);
        int l;
        l = blen();
        if (burst_interleave && burst_length_setting != BL_PAGE) begin
            return 9'((s & ~(l - 1)) | ((s ^ n) & (l - 1)));
        end
        return 9'((s & ~(l - 1)) | ((s + n) & (l - 1)));
    endfunction : colx

    task automatic chk_addr(input logic [22:0] got, input logic [22:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_addr

    task automatic chk_word(input logic [17:0] got, input logic [17:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    task automatic push_rd(input logic [1:0] b, input logic [11:0] r, input logic [8:0] c);
        ea_q.push_back({b, r, c});
        ew_q.push_back({2'h3, b, r[4:0], c});
    endtask : push_rd

    task automatic settle();
        ctl.idle(24);
        chk_word(18'(ga_q.size()), 18'(ea_q.size()));
        chk_word(18'(gw_q.size()), 18'(ew_q.size()));
        while (ea_q.size() > 0 && ga_q.size() > 0) begin
            chk_addr(ga_q.pop_front(), ea_q.pop_front());
        end
        while (ew_q.size() > 0 && gw_q.size() > 0) begin
            chk_word(gw_q.pop_front(), ew_q.pop_front());
        end
        ga_q.delete();
        ea_q.delete();
        gw_q.delete();
        ew_q.delete();
    endtask : settle

    task automatic access(input logic [1:0] b, input logic ap, input logic wr);
        logic [11:0] r;
        logic [8:0] c;
        logic [15:0] d;
        logic [1:0] m;
        r = 12'(rnd());
        c = 9'(rnd());
        d = 16'(rnd());
        m = wr ? 2'(rnd()) : 2'h0;
        ctl.cmd(CMD_ACT, b, r, 16'h0000, 2'h0);
        ctl.idle(2);
        for (int n = 0; n < blen(); n++) begin
            if (wr) begin
                ea_q.push_back({b, r, colx(c, n)});
                ew_q.push_back({~m, d});
            end else begin
                push_rd(b, r, colx(c, n));
            end
            if (n == 0) begin
                ctl.cmd(wr ? CMD_WR : CMD_RD, b, {1'b0, ap, 1'b0, c}, d, m);
            end else if (wr) begin
                ctl.cmd(CMD_NOP, b, 12'h000, d, m);
            end
            d = 16'(rnd());
            m = wr ? 2'(rnd()) : 2'h0;
        end
        settle();
        chk_word(18'(bank_open[b]), 18'(!ap));
        if (!ap) begin
            ctl.cmd(CMD_PRE, b, 12'h000, 16'h0000, 2'h0);
        end
    endtask : access

    task automatic complete_run();
        if (fail_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        complete_run();
    end

    initial begin
        int e;
        rst_n = 1'b0;
        burst_length_setting = BL_1;
        burst_interleave = 1'b0;
        read_latency_setting = 2'h2;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            ctl.cmd(CMD_REF, 2'h0, 12'h000, 16'h0000, 2'h0);
        end
        settle();
        chk_word(18'(refresh_row), 18'h5);
        e = err_seen;
        ctl.cmd(CMD_RD, 2'h2, 12'h005, 16'h0000, 2'h0);
        settle();
        chk_word(18'(err_seen - e), 18'h1);
        for (int k = 0; k < 24; k++) begin
            burst_length_setting <= (k % 4 == 0) ? BL_1 : 3'(k % 4);
            burst_interleave <= k[2];
            read_latency_setting <= 2'(1 + k % 3);
            access(2'(rnd()), k[3], k[0]);
        end
        // back-to-back column commands, other bank precharged meanwhile
        burst_length_setting <= BL_4;
        burst_interleave <= 1'b0;
        ctl.cmd(CMD_ACT, 2'h0, 12'h123, 16'h0000, 2'h0);
        ctl.cmd(CMD_ACT, 2'h1, 12'h0AB, 16'h0000, 2'h0);
        ctl.idle(2);
        ctl.cmd(CMD_RD, 2'h1, 12'h010, 16'h0000, 2'h0);
        ctl.cmd(CMD_RD, 2'h1, 12'h037, 16'h0000, 2'h0);
        ctl.cmd(CMD_PRE, 2'h0, 12'h000, 16'h0000, 2'h0);
        push_rd(2'h1, 12'h0AB, 9'h010);
        for (int n = 0; n < 4; n++) begin
            push_rd(2'h1, 12'h0AB, 9'h034 | 9'((n + 3) % 4));
        end
        settle();
        chk_word(18'(bank_open), 18'h2);
        // full page across the column wrap, cut by burst terminate
        burst_length_setting <= BL_PAGE;
        ctl.cmd(CMD_ACT, 2'h3, 12'hFFF, 16'h0000, 2'h0);
        ctl.idle(2);
        ctl.cmd(CMD_RD, 2'h3, 12'h1FE, 16'h0000, 2'h0);
        ctl.idle(4);
        ctl.cmd(CMD_BST, 2'h3, 12'h000, 16'h0000, 2'h0);
        for (int n = 0; n < 5; n++) begin
            push_rd(2'h3, 12'hFFF, 9'(9'h1FE + n));
        end
        settle();
        complete_run();
    end
endmodule : tb_top
